// ---- logic/autoneg_advertisement_register.sv ----
// Auto-negotiation advertisement register with AXI4-Lite access
`timescale 1ns/1ns
module autoneg_advertisement_register
  import anar_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire anar_pkg::strap_t strap,
  input wire logic negotiation_start,
  output anar_pkg::page_t base_page,
  output logic [15:0] ability
);
  import anar_pkg::*;

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic in_reset;
  logic start_pending;
  logic sw_start;
  logic do_write;
  logic [15:0] next_ability;
  logic [15:0] wr_merged;
  page_state_t page_state;

  // True when a selector code is one software may use
  function automatic logic sel_ok(input logic [4:0] code);
    sel_ok = (code == SEL_802_3) || (code == SEL_802_9);
  endfunction

  // True when an address decodes to a mapped register
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ADDR_ABILITY) || (a == ADDR_STRAP) ||
               (a == ADDR_CTRL) || (a == ADDR_PAGE);
  endfunction

  // Ready only while the matching half is not yet captured
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= addr_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Byte-lane merge; reserved positions forced to zero
  always_comb begin
    wr_merged = ability;
    if (w_strb_q[0]) begin
      wr_merged[7:0] = w_data_q[7:0];
    end
    if (w_strb_q[1]) begin
      wr_merged[15:8] = w_data_q[15:8];
    end
    wr_merged = wr_merged & WRITABLE_MASK;
  end

  // Flag set while reset is held; strap levels are caught on the first edge after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= 1'b0;
    end
  end

  // Next ability value: strap load first cycle out of reset, else writes
  always_comb begin
    next_ability = ability;
    if (in_reset) begin
      next_ability = ABILITY_FIXED_RESET;
      next_ability[POS_PAUSE] = strap.pause;
      next_ability[POS_TX_FD] = strap.tx_fd;
      next_ability[POS_TX_HD] = strap.tx_hd;
      next_ability[POS_T_FD] = strap.t_fd;
      next_ability[POS_T_HD] = strap.t_hd;
    end else if (do_write && aw_addr_q == ADDR_ABILITY) begin
      // Bits 15,13,11..0 all read/write
      next_ability = wr_merged;
    end
  end

  // Reset takes constants; strap levels land on the first released edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ability <= ABILITY_FIXED_RESET;
    end else begin
      ability <= next_ability;
    end
  end

  // Software start through the control register, bit 0
  assign sw_start = do_write && aw_addr_q == ADDR_CTRL &&
                    w_strb_q[0] && w_data_q[CTRL_START];

  // Latest contents are sampled at each start, never an older copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_pending <= 1'b0;
    end else begin
      start_pending <= negotiation_start || sw_start;
    end
  end

  // Page capture: load on a start, then hold until the next one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_state <= ST_IDLE;
      base_page <= '0;
    end else begin
      case (page_state)
        ST_IDLE: begin
          if (start_pending) begin
            page_state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          base_page.word <= ability;
          base_page.valid <= 1'b1;
          page_state <= ST_HOLD;
        end
        ST_HOLD: begin
          // A later write waits for the next start
          if (start_pending) begin
            page_state <= ST_LOAD;
          end
        end
        default: begin
          page_state <= ST_IDLE;
        end
      endcase
    end
  end

  // Read channel; one read outstanding, data registered
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        // Reserved bits are stored as zero so they read zero
        ADDR_ABILITY: rdata <= {16'h0000, ability};
        ADDR_STRAP: rdata <= {27'h0000000, strap};
        // Status flag helps software honour the selector code limits
        ADDR_CTRL: rdata <= {30'h00000000,
                             sel_ok(ability[SEL_W-1:POS_SEL_LO]),
                             1'b0};
        ADDR_PAGE: rdata <= {15'h0000, base_page};
        default: rdata <= 32'h0000_0000;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// ---- logic/anar_pkg.sv ----
// Package: register map, field layout and types for the advertisement block
package anar_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_ABILITY = 8'h10;
  localparam logic [7:0] ADDR_STRAP = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_PAGE = 8'h1c;

  // Field positions in the ability word
  localparam int POS_NEXT_PAGE = 15;
  localparam int POS_RSVD_HI = 14;
  localparam int POS_REMOTE_FAULT = 13;
  localparam int POS_RSVD_LO = 12;
  localparam int POS_ASYM_PAUSE = 11;
  localparam int POS_PAUSE = 10;
  localparam int POS_T4 = 9;
  localparam int POS_TX_FD = 8;
  localparam int POS_TX_HD = 7;
  localparam int POS_T_FD = 6;
  localparam int POS_T_HD = 5;
  localparam int POS_SEL_LO = 0;
  localparam int SEL_W = 5;

  // Bits software may change; reserved positions excluded
  localparam logic [15:0] WRITABLE_MASK = 16'hafff;

  // Selector codes and reset value of fixed fields
  localparam logic [4:0] SEL_802_3 = 5'h01;
  localparam logic [4:0] SEL_802_9 = 5'h02;
  localparam logic [4:0] SEL_RSVD_LOW = 5'h00;
  localparam logic [4:0] SEL_RSVD_HIGH = 5'h1f;
  localparam logic [15:0] ABILITY_FIXED_RESET = 16'h0001;

  // Control register bits
  localparam int CTRL_START = 0;
  localparam int CTRL_SEL_VALID = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Strap pins sampled at reset
  typedef struct packed {
    logic pause;
    logic tx_fd;
    logic tx_hd;
    logic t_fd;
    logic t_hd;
  } strap_t;

  // Base page handed to the negotiation engine
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } page_t;

  // Capture state; Gray order along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_HOLD = 2'b11
  } page_state_t;

endpackage

// ---- dv/anar_chk.sv ----
// Checker: port-level properties of the advertisement register
`timescale 1ns/1ns
module anar_chk
  import anar_pkg::*;
(
  input wire logic aclk, aresetn, awvalid, awready, wvalid, wready,
  input wire logic bvalid, arvalid, arready, rvalid, negotiation_start,
  input wire logic [7:0] awaddr, araddr,
  input wire logic [31:0] wdata, rdata,
  input wire logic [1:0] bresp, rresp,
  input wire strap_t strap,
  input wire page_t base_page,
  input wire logic [15:0] ability
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both halves of a write taken at one edge
  sequence s_wr(logic [7:0] a);
    awvalid && awready && wvalid && wready && awaddr == a;
  endsequence
  sequence s_rd;
    arvalid && arready && araddr == ADDR_ABILITY;
  endsequence
  property p_strap;
    $rose(aresetn) |=> ability == {5'h00, strap[4], 1'b0, strap[3:0], 5'h01};
  endproperty
  a_strap: assert property (p_strap) else $error("strap reset");
  property p_wr;
    s_wr(ADDR_ABILITY) |-> ##2 bvalid && bresp == RESP_OKAY &&
      ability == (WRITABLE_MASK & $past(wdata[15:0], 2));
  endproperty
  a_wr: assert property (p_wr) else $error("write value");
  property p_bad;
    s_wr(8'h04) |-> ##2 bvalid && bresp == RESP_SLVERR;
  endproperty
  a_bad: assert property (p_bad) else $error("unmapped write");
  property p_rd;
    s_rd |=> rvalid && rresp == RESP_OKAY &&
      rdata == {16'h0000, $past(ability)};
  endproperty
  a_rd: assert property (p_rd) else $error("read value");
  property p_rsv;
    ability[POS_RSVD_HI] == 1'b0 && ability[POS_RSVD_LO] == 1'b0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_idle;
    (!(awvalid && wvalid))[*3] |=> $stable(ability);
  endproperty
  a_idle: assert property (p_idle) else $error("ability drifted");
  property p_neg;
    negotiation_start |->
      ##[2:3] (base_page.valid && base_page.word == ability);
  endproperty
  a_neg: assert property (p_neg) else $error("page capture");
  // Page must not follow later writes until a new start
  property p_hold;
    (!negotiation_start && !bvalid)[*3] |=> $stable(base_page);
  endproperty
  a_hold: assert property (p_hold) else $error("page moved");
endmodule

bind autoneg_advertisement_register anar_chk u_anar_chk (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .rvalid, .negotiation_start, .awaddr, .araddr, .wdata, .rdata, .bresp,
  .rresp, .strap, .base_page, .ability);

// ---- dv/tb.sv ----
// Testbench: strap reset, field access, unmapped and page capture
`timescale 1ns/1ns
module tb;
  import anar_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, negotiation_start = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [1:0] bresp, rresp;
  logic [4:0] s, strap = '0;
  page_t base_page;
  logic [15:0] ability, v;
  logic [33:0] q[$];
  int n_mismatch = 0, tests_run = 0;
  always #2 aclk = ~aclk;
  autoneg_advertisement_register u_autoneg_advertisement_register (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .strap,
    .negotiation_start, .base_page, .ability);
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Oldest note against each response as it is taken
  always @(negedge aclk) begin
    if (bvalid && bready) chk({bresp, 32'h0});
    if (rvalid && rready) chk({rresp, rdata});
  end
  task automatic chk(input logic [33:0] g);
    logic [33:0] e;
    e = q.pop_front();
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Readies sampled mid-cycle, so each channel drops at its own edge
  task automatic wr(input logic [7:0] a, input logic [31:0] x,
                    input logic [1:0] r = RESP_OKAY);
    bit ta, tw, ah, wh;
    q.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      ah |= ta;
      wh |= tw;
    end while (!(ah && wh));
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [1:0] r = RESP_OKAY);
    q.push_back({r, x});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // Straps held steady across reset and the load edge
  task automatic rst(input logic [4:0] p);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap <= p;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    s = 5'($urandom(31));
    for (int i = 0; i < 2; i++) begin
      if (i == 1) s = ~s;
      rst(s);
      rd(ADDR_ABILITY, {21'h0, s[4], 1'b0, s[3:0], 5'h01});
      rd(ADDR_STRAP, {27'h0, s});
    end
    $display("test reset done");
    for (int i = 5; i < 16; i++) begin
      // Reserved bit 12 is always written as zero
      v = 16'h0001 | (16'h0001 << i) & ~16'h1000;
      wr(ADDR_ABILITY, {16'h0, v});
      rd(ADDR_ABILITY, {16'h0, v & WRITABLE_MASK});
    end
    repeat (4) begin
      d = $urandom() & 32'hffffefe0 | 32'h00000002;
      v = d[15:0] & WRITABLE_MASK;
      wr(ADDR_ABILITY, d);
      rd(ADDR_ABILITY, {16'h0, v});
    end
    $display("test fields done");
    rd(8'h00, 32'h0, RESP_SLVERR);
    wr(8'h04, 32'hffff, RESP_SLVERR);
    rd(ADDR_ABILITY, {16'h0, v});
    $display("test unmapped done");
    @(posedge aclk) negotiation_start <= 1'b1;
    @(posedge aclk) negotiation_start <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(ADDR_PAGE, {15'h0, 1'b1, v});
    wr(ADDR_ABILITY, 32'h00008001);
    rd(ADDR_PAGE, {15'h0, 1'b1, v});
    wr(ADDR_CTRL, 32'h00000001);
    repeat (3) @(posedge aclk);
    rd(ADDR_PAGE, 32'h00018001);
    $display("test page done");
    report_and_stop();
  end
  // Whole run needs well under this span
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
